// ---- src/rtxa_core.sv ----
// Purpose: Link-layer addressing, status, retry and encryption gating of a low-rate radio
// Assumes: All inputs except rst_n_i synchronous to ref_clk_i; RF engine reports one result per send
// Notes: Cipher itself is outside; this core only steers and filters
`timescale 1ns/1ns
`include "rtxa_params.svh"

module rtxa_core #(
  parameter logic [31:0] SERIAL_UPPER = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] SERIAL_LOWER = 32'h0000_0002, // Arbitrary value
  parameter logic [7:0] PAYLOAD_PLAIN = 8'h64, // Long-address payload, no cipher
  parameter logic [7:0] PAYLOAD_ENC = 8'h5a // Long-address payload, cipher on
) (
  input wire logic ref_clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic cfg_wr_i, // Register write strobe
  input wire logic cfg_rd_i, // Register read strobe
  input wire logic [3:0] cfg_idx_i, // Register index
  input wire logic [31:0] cfg_wdata_i, // Write data
  output logic [31:0] cfg_rdata_o, // Read data
  output logic cfg_rvalid_o, // Read data valid pulse

  input wire logic scan_refused_i, // Coordinator refuses associations
  input wire logic scan_pan_mismatch_i, // Found PAN with other identifier
  input wire logic scan_chan_mismatch_i, // Found PAN on other channel
  input wire logic assoc_no_resp_i, // Association request unanswered
  input wire logic assoc_ok_i, // Started or associated
  input wire logic disassoc_i, // Disassociated or disassociating
  input wire logic [63:0] coord_addr_i, // Coordinator address with assoc_ok_i

  input wire logic tx_req_i, // Send request
  input wire logic [7:0] tx_frame_opts_i, // Per-frame options
  input wire logic [7:0] tx_len_i, // Payload bytes
  input wire logic tx_result_i, // One send finished
  input wire logic tx_acked_i, // That send was acknowledged

  input wire logic rx_valid_i, // Received packet pulse
  input wire logic rx_dst_long_i, // Destination field is 64-bit
  input wire logic [63:0] rx_dst_i, // Destination field
  input wire logic rx_encrypted_i, // Packet was encrypted
  input wire logic rx_ack_req_i, // Header asks for acknowledgment

  output logic [7:0] max_payload_o, // Current payload limit
  output logic tx_busy_o, // Request in progress
  output logic tx_start_o, // Send one packet pulse
  output logic [63:0] tx_dest_o, // Destination for the send
  output logic tx_short_dest_o, // Use 16-bit destination
  output logic tx_bcast_o, // Broadcast send
  output logic tx_ack_req_o, // Header ack request bit
  output logic tx_mac_ack_o, // Expect MAC acknowledgment
  output logic tx_src_long_o, // Use 64-bit source
  output logic tx_encrypt_o, // Cipher the payload
  output logic tx_bcast_pan_o, // Broadcast PAN identifier
  output logic tx_secure_o, // Secure-session send
  output logic tx_done_o, // Request succeeded pulse
  output logic tx_fail_o, // Request failed pulse

  output logic rx_deliver_o, // Forward packet to host pulse
  output logic rx_long_ind_o, // Report as 64-bit indication
  output logic rx_send_ack_o // Return acknowledgment pulse
);

  rtxa_pkg::rtxa_state_t s_q;
  rtxa_pkg::rtxa_state_t s_d;
  logic [7:0] np_cur;
  logic [7:0] eff_opts;
  logic [63:0] dest64;
  logic dest_bcast;
  logic dest_short;
  logic short_off;
  logic app_hdr;
  logic mac_acks;
  logic [7:0] len_limit;

  // Derived addressing and payload terms, shared by both paths
  always_comb begin
    dest64 = {s_q.dest_upper, s_q.dest_lower};
    dest_bcast = (s_q.dest_upper == 32'h0) &&
                 (s_q.dest_lower == `RTXA_BCAST_LOWER);
    dest_short = (s_q.dest_upper == 32'h0) &&
                 (s_q.dest_lower < `RTXA_BCAST_LOWER);
    short_off = (s_q.short_src_addr == `RTXA_SHORT_OFF) ||
                (s_q.short_src_addr == `RTXA_SHORT_OFF_OLD);

    // Modes 0 and 3 carry the app header; modes 0 and 2 use MAC acknowledgments
    app_hdr = (s_q.mac_header_mode == 2'h0) || (s_q.mac_header_mode == 2'h3);
    mac_acks = (s_q.mac_header_mode == 2'h0) || (s_q.mac_header_mode == 2'h2);

    // Transparent uses stored options; framed uses them only when frame gives zero
    if (s_q.framed_interface_sel == 2'h0 || tx_frame_opts_i == 8'h00) begin
      eff_opts = s_q.tx_option_flags;
    end else begin
      eff_opts = tx_frame_opts_i;
    end

    if (s_q.encryption_on && s_q.compat_opts[`RTXA_COMPAT_TX]) begin
      np_cur = `RTXA_ENC_COMPAT_MAX;
    end else if (s_q.encryption_on) begin
      np_cur = PAYLOAD_ENC;
    end else begin
      np_cur = PAYLOAD_PLAIN;
    end
    if (s_q.tx_option_flags[`RTXA_OPT_SECURE]) begin
      np_cur = np_cur - `RTXA_SECURE_PENALTY;
    end

    // Secure bit of this request also costs four bytes
    len_limit = np_cur;
    if (eff_opts[`RTXA_OPT_SECURE] && !s_q.tx_option_flags[`RTXA_OPT_SECURE]) begin
      len_limit = np_cur - `RTXA_SECURE_PENALTY;
    end
    if (dest_short) begin
      len_limit = len_limit + `RTXA_SHORT_EXTRA;
    end
  end

  // Next-state logic for registers, status, transmit and receive paths
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.tx_start = 1'b0;
    s_d.tx_done = 1'b0;
    s_d.tx_fail = 1'b0;
    s_d.rx_deliver = 1'b0;
    s_d.rx_long_ind = 1'b0;
    s_d.rx_send_ack = 1'b0;
    s_d.max_payload = np_cur;

    // Register reads; read-only entries other than the serial halves reflect live state
    if (cfg_rd_i) begin
      s_d.rvalid = 1'b1;
      case (cfg_idx_i)
        `RTXA_IDX_ASSOC_STATUS:
          s_d.rdata = {24'h0, s_q.assoc_status};
        `RTXA_IDX_SERIAL_UPPER:
          s_d.rdata = SERIAL_UPPER;
        `RTXA_IDX_SERIAL_LOWER:
          s_d.rdata = SERIAL_LOWER;
        `RTXA_IDX_SHORT_SRC:
          s_d.rdata = {16'h0, s_q.short_src_addr};
        `RTXA_IDX_DEST_UPPER:
          s_d.rdata = s_q.dest_upper;
        `RTXA_IDX_DEST_LOWER:
          s_d.rdata = s_q.dest_lower;
        `RTXA_IDX_APP_RETRY:
          s_d.rdata = {29'h0, s_q.app_retry_count};
        `RTXA_IDX_TX_OPTS:
          s_d.rdata = {24'h0, s_q.tx_option_flags};
        `RTXA_IDX_MAX_PAYLOAD:
          s_d.rdata = {24'h0, np_cur};
        `RTXA_IDX_ENCRYPT:
          s_d.rdata = {31'h0, s_q.encryption_on};
        `RTXA_IDX_MAC_MODE:
          s_d.rdata = {30'h0, s_q.mac_header_mode};
        `RTXA_IDX_ASSOC_OPTS:
          s_d.rdata = {28'h0, s_q.enddev_assoc_opts};
        `RTXA_IDX_FRAMED_SEL:
          s_d.rdata = {30'h0, s_q.framed_interface_sel};
        `RTXA_IDX_COMPAT:
          s_d.rdata = {24'h0, s_q.compat_opts};
        default:
          s_d.rdata = 32'h0;
      endcase
    end

    // Register writes; out-of-range retry counts and cipher values are ignored, other fields keep their low bits, read-only ones drop
    if (cfg_wr_i) begin
      case (cfg_idx_i)
        `RTXA_IDX_SHORT_SRC:
          s_d.short_src_addr = cfg_wdata_i[15:0];
        `RTXA_IDX_DEST_UPPER:
          s_d.dest_upper = cfg_wdata_i;
        `RTXA_IDX_DEST_LOWER:
          s_d.dest_lower = cfg_wdata_i;
        `RTXA_IDX_APP_RETRY: begin
          if (cfg_wdata_i <= {29'h0, `RTXA_APP_RETRY_MAX}) begin
            s_d.app_retry_count = cfg_wdata_i[2:0];
          end
        end
        `RTXA_IDX_TX_OPTS:
          s_d.tx_option_flags = cfg_wdata_i[7:0];
        `RTXA_IDX_ENCRYPT: begin
          if (cfg_wdata_i[31:1] == 31'h0) begin
            s_d.encryption_on = cfg_wdata_i[0];
          end
        end
        `RTXA_IDX_MAC_MODE:
          s_d.mac_header_mode = cfg_wdata_i[1:0];
        `RTXA_IDX_ASSOC_OPTS:
          s_d.enddev_assoc_opts = cfg_wdata_i[3:0];
        `RTXA_IDX_FRAMED_SEL:
          s_d.framed_interface_sel = cfg_wdata_i[1:0];
        `RTXA_IDX_COMPAT:
          s_d.compat_opts = cfg_wdata_i[7:0];
        default:
          ;
      endcase
    end

    // Association status; peer mode needs no association at all
    if (!s_q.enddev_assoc_opts[`RTXA_AOPT_AUTO_ASSOC]) begin
      if (assoc_ok_i) begin
        s_d.assoc_status = `RTXA_ST_OK;
      end
    end else if (disassoc_i) begin
      s_d.assoc_status = `RTXA_ST_DISASSOC;
    end else if (assoc_ok_i) begin
      s_d.assoc_status = `RTXA_ST_OK;
      s_d.dest_upper = coord_addr_i[63:32];
      s_d.dest_lower = coord_addr_i[31:0];
    end else if (assoc_no_resp_i) begin
      s_d.assoc_status = `RTXA_ST_NO_RESP;
    end else if (scan_pan_mismatch_i &&
                 !s_q.enddev_assoc_opts[`RTXA_AOPT_PAN_REASSIGN]) begin
      s_d.assoc_status = `RTXA_ST_PAN_MISMATCH;
    end else if (scan_chan_mismatch_i &&
                 !s_q.enddev_assoc_opts[`RTXA_AOPT_CHAN_REASSIGN]) begin
      s_d.assoc_status = `RTXA_ST_CHAN_MISMATCH;
    end else if (scan_refused_i) begin
      s_d.assoc_status = `RTXA_ST_REFUSED;
    end

    // Transmit sequencer: one request, several sends
    case (s_q.tx_state)
      rtxa_pkg::TX_IDLE: begin
        if (tx_req_i) begin
          s_d.tx_dest = dest64;
          s_d.tx_short_dest = dest_short;
          s_d.tx_bcast = dest_bcast;
          s_d.tx_src_long = short_off || s_q.encryption_on;
          s_d.tx_encrypt = s_q.encryption_on;
          s_d.tx_bcast_pan = eff_opts[`RTXA_OPT_BCAST_PAN];
          s_d.tx_secure = eff_opts[`RTXA_OPT_SECURE];

          s_d.tx_acks = !dest_bcast && mac_acks && !eff_opts[`RTXA_OPT_NO_ACK];
          s_d.tx_ack_req = !dest_bcast && app_hdr && (s_q.app_retry_count != 3'h0);
          s_d.mac_left = `RTXA_MAC_SENDS;
          s_d.app_left = app_hdr ? s_q.app_retry_count : 3'h0;

          if (s_q.app_retry_count == 3'h0) begin
            s_d.bc_left = 4'h1;
          end else begin
            s_d.bc_left = {1'b0, s_q.app_retry_count} + `RTXA_BCAST_EXTRA;
          end
          // Oversize payload fails at once, nothing goes on air
          if (tx_len_i > len_limit) begin
            s_d.tx_fail = 1'b1;
          end else begin
            s_d.tx_start = 1'b1;
            s_d.tx_state = rtxa_pkg::TX_WAIT;
          end
        end
      end
      rtxa_pkg::TX_WAIT: begin
        if (tx_result_i) begin
          if (s_q.tx_bcast) begin
            // Broadcasts expect no acknowledgment
            s_d.bc_left = s_q.bc_left - 4'h1;
            if (s_q.bc_left == 4'h1) begin
              s_d.tx_done = 1'b1;
              s_d.tx_state = rtxa_pkg::TX_IDLE;
            end else begin
              s_d.tx_start = 1'b1;
            end
          end else if (!s_q.tx_acks || tx_acked_i) begin
            s_d.tx_done = 1'b1;
            s_d.tx_state = rtxa_pkg::TX_IDLE;
          end else if (s_q.mac_left != 3'h1) begin
            s_d.mac_left = s_q.mac_left - 3'h1;
            s_d.tx_start = 1'b1;
          end else if (s_q.app_left != 3'h0) begin
            s_d.app_left = s_q.app_left - 3'h1;
            s_d.mac_left = `RTXA_MAC_SENDS;
            s_d.tx_start = 1'b1;
          end else begin
            s_d.tx_fail = 1'b1;
            s_d.tx_state = rtxa_pkg::TX_IDLE;
          end
        end
      end
      default: s_d.tx_state = rtxa_pkg::TX_IDLE;
    endcase

    // Receive filter: cipher gate first, then address match
    if (rx_valid_i && (rx_encrypted_i || !s_q.encryption_on)) begin
      if (rx_dst_long_i) begin
        if (rx_dst_i == {SERIAL_UPPER, SERIAL_LOWER}) begin
          s_d.rx_deliver = 1'b1;
          s_d.rx_send_ack = rx_ack_req_i;
        end
      end else if (rx_dst_i[15:0] == `RTXA_SHORT_OFF_OLD) begin
        s_d.rx_deliver = 1'b1;
      end else if (!short_off && rx_dst_i[15:0] == s_q.short_src_addr) begin
        s_d.rx_deliver = 1'b1;
        s_d.rx_send_ack = rx_ack_req_i;
      end

      s_d.rx_long_ind = rx_dst_long_i || (s_q.encryption_on && !short_off &&
                        (s_q.mac_header_mode == 2'h1 || s_q.mac_header_mode == 2'h2) &&
                        s_q.framed_interface_sel != 2'h0);
    end
  end

  // State register; constants only under reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.assoc_status <= `RTXA_ST_INIT;
      s_q.short_src_addr <= `RTXA_RST_SHORT_SRC;
      s_q.dest_upper <= `RTXA_RST_DEST;
      s_q.dest_lower <= `RTXA_RST_DEST;
      s_q.app_retry_count <= `RTXA_RST_APP_RETRY;
      s_q.tx_option_flags <= `RTXA_RST_TX_OPTS;
      s_q.encryption_on <= `RTXA_RST_ENCRYPT;
      s_q.mac_header_mode <= `RTXA_RST_MAC_MODE;
      s_q.enddev_assoc_opts <= `RTXA_RST_ASSOC_OPTS;
      s_q.compat_opts <= `RTXA_RST_COMPAT;
      s_q.framed_interface_sel <= `RTXA_RST_FRAMED_SEL;
      s_q.tx_state <= rtxa_pkg::TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign cfg_rdata_o = s_q.rdata;
  assign cfg_rvalid_o = s_q.rvalid;

  assign max_payload_o = s_q.max_payload;

  assign tx_busy_o = (s_q.tx_state != rtxa_pkg::TX_IDLE);
  assign tx_start_o = s_q.tx_start;

  assign tx_dest_o = s_q.tx_dest;
  assign tx_short_dest_o = s_q.tx_short_dest;
  assign tx_bcast_o = s_q.tx_bcast;
  assign tx_ack_req_o = s_q.tx_ack_req;
  assign tx_mac_ack_o = s_q.tx_acks;
  assign tx_src_long_o = s_q.tx_src_long;
  assign tx_encrypt_o = s_q.tx_encrypt;
  assign tx_bcast_pan_o = s_q.tx_bcast_pan;
  assign tx_secure_o = s_q.tx_secure;

  assign tx_done_o = s_q.tx_done;
  assign tx_fail_o = s_q.tx_fail;

  assign rx_deliver_o = s_q.rx_deliver;
  assign rx_long_ind_o = s_q.rx_long_ind;
  assign rx_send_ack_o = s_q.rx_send_ack;

endmodule : rtxa_core

// ---- src/rtxa_params.svh ----
// Purpose: Offsets, reset values, codes and counts for the radio addressing and retry core
// Assumes: Register indices are command selectors on the configuration port
// Notes: Included by its bare name
`ifndef RTXA_PARAMS_SVH
`define RTXA_PARAMS_SVH
// Configuration port register indices
`define RTXA_IDX_ASSOC_STATUS 4'h0
`define RTXA_IDX_SERIAL_UPPER 4'h1
`define RTXA_IDX_SERIAL_LOWER 4'h2
`define RTXA_IDX_SHORT_SRC 4'h3
`define RTXA_IDX_DEST_UPPER 4'h4
`define RTXA_IDX_DEST_LOWER 4'h5
`define RTXA_IDX_APP_RETRY 4'h6
`define RTXA_IDX_TX_OPTS 4'h7
`define RTXA_IDX_MAX_PAYLOAD 4'h8
`define RTXA_IDX_ENCRYPT 4'h9
`define RTXA_IDX_MAC_MODE 4'ha
`define RTXA_IDX_ASSOC_OPTS 4'hb
`define RTXA_IDX_FRAMED_SEL 4'hc
`define RTXA_IDX_COMPAT 4'hd
// Reset values
`define RTXA_RST_SHORT_SRC 16'h0000
`define RTXA_RST_DEST 32'h0000_0000
`define RTXA_RST_APP_RETRY 3'h0
`define RTXA_RST_TX_OPTS 8'h00
`define RTXA_RST_ENCRYPT 1'b0
`define RTXA_RST_MAC_MODE 2'h0
`define RTXA_RST_ASSOC_OPTS 4'h0
`define RTXA_RST_FRAMED_SEL 2'h0
`define RTXA_RST_COMPAT 8'h00
// Association status codes
`define RTXA_ST_OK 8'h00
`define RTXA_ST_REFUSED 8'h03
`define RTXA_ST_PAN_MISMATCH 8'h05
`define RTXA_ST_CHAN_MISMATCH 8'h06
`define RTXA_ST_NO_RESP 8'h0c
`define RTXA_ST_DISASSOC 8'h13
`define RTXA_ST_INIT 8'hff
// Address constants
`define RTXA_SHORT_OFF 16'hfffe
`define RTXA_SHORT_OFF_OLD 16'hffff
`define RTXA_BCAST_LOWER 32'h0000_ffff
// Option bit positions
`define RTXA_OPT_NO_ACK 0
`define RTXA_OPT_BCAST_PAN 2
`define RTXA_OPT_SECURE 4
`define RTXA_AOPT_PAN_REASSIGN 0
`define RTXA_AOPT_CHAN_REASSIGN 1
`define RTXA_AOPT_AUTO_ASSOC 2
`define RTXA_COMPAT_TX 0
// Counts and sizes
`define RTXA_APP_RETRY_MAX 3'h6
`define RTXA_MAC_SENDS 3'h6
`define RTXA_BCAST_EXTRA 4'h2
`define RTXA_SHORT_EXTRA 8'h06
`define RTXA_SECURE_PENALTY 8'h04
`define RTXA_ENC_COMPAT_MAX 8'h5f
`endif

// ---- src/rtxa_pkg.sv ----
// Purpose: Types for the radio addressing and retry core
// Assumes: Constants live in rtxa_params.svh
// Notes: State of the core is one packed struct
package rtxa_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT} rtxa_tx_state_t;

  typedef struct packed {
    logic [7:0] assoc_status;
    logic [15:0] short_src_addr;
    logic [31:0] dest_upper;
    logic [31:0] dest_lower;
    logic [2:0] app_retry_count;
    logic [7:0] tx_option_flags;
    logic encryption_on;
    logic [1:0] mac_header_mode;
    logic [3:0] enddev_assoc_opts;
    logic [7:0] compat_opts;
    logic [1:0] framed_interface_sel;
    logic [31:0] rdata;
    logic rvalid;
    logic [7:0] max_payload;
    rtxa_tx_state_t tx_state;
    logic tx_bcast;
    logic tx_acks;
    logic [2:0] mac_left;
    logic [2:0] app_left;
    logic [3:0] bc_left;
    logic tx_start;
    logic [63:0] tx_dest;
    logic tx_short_dest;
    logic tx_ack_req;
    logic tx_src_long;
    logic tx_encrypt;
    logic tx_bcast_pan;
    logic tx_secure;
    logic tx_done;
    logic tx_fail;
    logic rx_deliver;
    logic rx_long_ind;
    logic rx_send_ack;
  } rtxa_state_t;
endpackage : rtxa_pkg

// ---- verif/rtxa_chk.sv ----
// Purpose: Port-level assertions for the core
// Assumes: Bound to rtxa_core; one clock domain
// Notes: Shadows the cipher switch from register writes
`timescale 1ns/1ns

module rtxa_chk #(
  parameter logic [31:0] SERIAL_UPPER = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] SERIAL_LOWER = 32'h0000_0002 // Arbitrary value
) (
  input logic ref_clk_i, // Clock
  input logic rst_n_i, // Reset
  input logic cfg_wr_i, // Write
  input logic cfg_rd_i, // Read
  input logic [3:0] cfg_idx_i, // Index
  input logic [31:0] cfg_wdata_i, // Wdata
  input logic [31:0] cfg_rdata_o, // Rdata
  input logic cfg_rvalid_o, // Rvalid
  input logic tx_req_i, // Request
  input logic tx_result_i, // Result
  input logic tx_acked_i, // Acked
  input logic rx_valid_i, // Rx pulse
  input logic rx_dst_long_i, // Long dst
  input logic [63:0] rx_dst_i, // Dst
  input logic rx_encrypted_i, // Ciphered
  input logic rx_ack_req_i, // Ack asked
  input logic tx_busy_o, // Busy
  input logic tx_start_o, // Send
  input logic [63:0] tx_dest_o, // Dest
  input logic tx_short_dest_o, // Short dest
  input logic tx_bcast_o, // Broadcast
  input logic tx_mac_ack_o, // Mac ack
  input logic tx_src_long_o, // Long src
  input logic tx_encrypt_o, // Cipher
  input logic tx_done_o, // Done
  input logic tx_fail_o, // Fail
  input logic rx_deliver_o, // Deliver
  input logic rx_long_ind_o, // Long ind
  input logic rx_send_ack_o // Ack out
);
  logic enc_q;
  logic enc_d;
  // Refused values leave the shadow alone, as in the core
  always_comb begin
    enc_d = enc_q;
    if (cfg_wr_i && cfg_idx_i == 4'h9 && cfg_wdata_i <= 32'h1) enc_d = cfg_wdata_i[0];
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) enc_q <= 1'h0;
    else enc_q <= enc_d;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req_taken;
    tx_req_i && !tx_busy_o;
  endsequence
  sequence s_own_rx;
    rx_valid_i && rx_dst_long_i && rx_dst_i == {SERIAL_UPPER, SERIAL_LOWER}
      && (!enc_q || rx_encrypted_i);
  endsequence
  a_read_answered: assert property (cfg_rd_i |=> cfg_rvalid_o) else $error("no rvalid");
  a_serial_upper: assert property (cfg_rd_i && cfg_idx_i == 4'h1 |=>
    cfg_rdata_o == SERIAL_UPPER) else $error("upper half");
  a_serial_lower: assert property (cfg_rd_i && cfg_idx_i == 4'h2 |=>
    cfg_rdata_o == SERIAL_LOWER) else $error("lower half");
  a_req_answered: assert property (s_req_taken |=> tx_start_o || tx_fail_o)
    else $error("request unanswered");
  a_short_dest_form: assert property (tx_start_o && tx_short_dest_o |->
    tx_dest_o[63:32] == 32'h0 && tx_dest_o[31:0] < 32'h0000_ffff) else $error("short dest");
  a_bcast_addr_kind: assert property (tx_start_o && tx_dest_o == 64'h0000_0000_0000_ffff |->
    tx_bcast_o && !tx_mac_ack_o) else $error("broadcast dest");
  a_enc_long_src: assert property (tx_start_o && enc_q |-> tx_src_long_o && tx_encrypt_o)
    else $error("cipher source");
  a_acked_done: assert property (tx_busy_o && tx_result_i && tx_acked_i && tx_mac_ack_o |=>
    tx_done_o && !tx_busy_o) else $error("ack not final");
  a_plain_dropped: assert property (enc_q && rx_valid_i && !rx_encrypted_i |=>
    !rx_deliver_o && !rx_send_ack_o) else $error("plain delivered");
  a_own_long_rx: assert property (s_own_rx |=> rx_deliver_o && rx_long_ind_o
    && rx_send_ack_o == $past(rx_ack_req_i)) else $error("own address");
endmodule : rtxa_chk

bind rtxa_core rtxa_chk #(.SERIAL_UPPER(SERIAL_UPPER), .SERIAL_LOWER(SERIAL_LOWER)) u_chk (.*);

// ---- verif/rtxa_rf_model.sv ----
// Purpose: RF engine and peer radios answering each send
// Assumes: One send in flight; answers at the falling edge
// Notes: Loses a set number of sends before acking; broadcasts never acked
`timescale 1ns/1ns

module rtxa_rf_model (
  input logic ref_clk_i, // Clock
  input logic rst_n_i, // Reset
  input logic start_i, // Send one packet
  input logic bcast_i, // Broadcast send
  input logic mac_ack_i, // Ack expected
  input logic end_i, // Request over
  input logic slow_i, // Answer late
  input logic [5:0] nacks_i, // Sends lost first
  output logic result_o, // Send finished
  output logic acked_o // Send acked
);
  logic [2:0] wait_q;
  logic [5:0] sent_q;
  // Answer after one or four cycles; idle ack line toggles so it is never trusted
  always @(negedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 3'h0;
      sent_q <= 6'h0;
      result_o <= 1'h0;
      acked_o <= 1'h0;
    end else begin
      result_o <= 1'h0;
      acked_o <= ~acked_o;
      if (start_i) wait_q <= slow_i ? 3'h4 : 3'h1;
      else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
      if (!start_i && wait_q == 3'h1) begin
        result_o <= 1'h1;
        acked_o <= mac_ack_i && !bcast_i && sent_q >= nacks_i;
        sent_q <= sent_q + 6'h1;
      end
      if (end_i) sent_q <= 6'h0;
    end
  end
endmodule : rtxa_rf_model

// ---- verif/radio_tx_addressing_retry_tb_top.sv ----
// Purpose: Self-checking bench for the core
// Assumes: Bench is the host; rf model is the far side
// Notes: Fixed-seed xorshift traffic with hand-picked corners
`timescale 1ns/1ns

module radio_tx_addressing_retry_tb_top;
  localparam logic [31:0] SU = 32'h1234_5678; // Arbitrary value
  localparam logic [31:0] SL = 32'h9abc_def0; // Arbitrary value
  localparam logic [7:0] PP = 8'h40;
  localparam logic [7:0] PE = 8'h30;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0, cfg_wr_i = 1'h0, cfg_rd_i = 1'h0, tx_req_i = 1'h0;
  logic rx_valid_i = 1'h0, rx_dst_long_i = 1'h0, rx_encrypted_i = 1'h0, rx_ack_req_i = 1'h0;
  logic [3:0] cfg_idx_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, r, seed = 32'h0001_31ee;
  logic [63:0] coord_addr_i = 64'h0, rx_dst_i = 64'h0, tx_dest_o;
  logic [7:0] tx_frame_opts_i = 8'h0, tx_len_i = 8'h0, max_payload_o, c_to = 8'h0;
  logic [5:0] ev = 6'h0, m_nacks = 6'h0;
  logic cfg_rvalid_o, tx_result_i, tx_acked_i, tx_busy_o, tx_start_o, tx_short_dest_o, c_enc;
  logic tx_bcast_o, tx_ack_req_o, tx_mac_ack_o, tx_src_long_o, tx_encrypt_o, tx_bcast_pan_o;
  logic tx_secure_o, tx_done_o, tx_fail_o, rx_deliver_o, rx_long_ind_o, rx_send_ack_o, m_slow;
  logic [1:0] c_mode = 2'h0;
  logic [2:0] c_rr = 3'h0;
  logic [15:0] c_my = 16'h0;
  logic [31:0] rv [15] = '{0: 32'hff, 1: SU, 2: SL, 8: PP, default: 32'h0};
  logic [31:0] st [6] = '{32'h03, 32'h05, 32'h06, 32'h0c, 32'h00, 32'h13};
  int n_fail = 0;
  int cmp_count = 0;

  rtxa_core #(.SERIAL_UPPER(SU), .SERIAL_LOWER(SL), .PAYLOAD_PLAIN(PP), .PAYLOAD_ENC(PE)) dut (
    .scan_refused_i(ev[5]), .scan_pan_mismatch_i(ev[4]), .scan_chan_mismatch_i(ev[3]),
    .assoc_no_resp_i(ev[2]), .assoc_ok_i(ev[1]), .disassoc_i(ev[0]), .*);
  rtxa_rf_model u_rf (.ref_clk_i, .rst_n_i, .start_i(tx_start_o), .bcast_i(tx_bcast_o),
    .mac_ack_i(tx_mac_ack_o), .end_i(tx_done_o | tx_fail_o), .slow_i(m_slow),
    .nacks_i(m_nacks), .result_o(tx_result_i), .acked_o(tx_acked_i));

  // 50 MHz clock
  always #10 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Host strobes last one cycle and are set between clock edges
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(negedge ref_clk_i);
    {cfg_wr_i, cfg_idx_i, cfg_wdata_i} = {1'h1, i, d};
    @(negedge ref_clk_i);
    cfg_wr_i = 1'h0;
  endtask : wr

  task automatic rdc(input logic [3:0] i, input logic [31:0] e);
    @(negedge ref_clk_i);
    {cfg_rd_i, cfg_idx_i} = {1'h1, i};
    @(negedge ref_clk_i);
    cfg_rd_i = 1'h0;
    chk(cfg_rvalid_o, 64'h1);
    chk(cfg_rdata_o, e);
    if (i == 4'h8) chk(max_payload_o, e);
  endtask : rdc

  task automatic evp(input logic [5:0] m);
    @(negedge ref_clk_i);
    ev = m;
    @(negedge ref_clk_i);
    ev = 6'h0;
  endtask : evp

  task automatic rxc(input logic lg, input logic [63:0] dst, input logic en, input logic ak,
      input logic del, input logic li);
    @(negedge ref_clk_i);
    {rx_valid_i, rx_dst_long_i, rx_dst_i, rx_encrypted_i, rx_ack_req_i} = {1'h1, lg, dst, en, ak};
    @(negedge ref_clk_i);
    {rx_valid_i, rx_dst_i} = {1'h0, ~dst};
    chk({rx_deliver_o, rx_long_ind_o, rx_send_ack_o}, {del, del & li, del & ak});
  endtask : rxc

  // One request: kind 0 short, 1 broadcast, 2 long
  task automatic txr(input logic [1:0] kind, input logic [7:0] fo, input logic [5:0] nk);
    logic [63:0] d;
    logic [31:0] q;
    logic [7:0] eo, lim, len;
    logic sh, bc, ma, fin, fl;
    int n, ex, bud;
    q = rnd();
    d = kind == 2'h0 ? {48'h0, q[15:0] & 16'hfffe} : kind == 2'h1 ? 64'hffff : {q | 32'h1, ~q};
    wr(4'h4, d[63:32]);
    wr(4'h5, d[31:0]);
    {sh, bc, eo} = {kind == 2'h0, kind == 2'h1, fo != 8'h0 ? fo : c_to};
    ma = !bc && !eo[0] && (c_mode == 2'h0 || c_mode == 2'h2);
    lim = (c_enc ? PE : PP) + (sh ? 8'h06 : 8'h00) - (eo[4] ? 8'h04 : 8'h00);
    len = (bc || q[17:16] == 2'h0) ? 8'h10 : q[16] ? lim : lim + 8'h01;
    bud = ma ? 6 * ((c_mode == 2'h0 ? c_rr : 3'h0) + 1) : 1;
    ex = len > lim ? 0 : bc ? (c_rr == 3'h0 ? 1 : c_rr + 2) : ma && nk < bud ? nk + 1 : bud;
    fl = len > lim || (ma && nk >= bud);
    {m_nacks, m_slow, n, fin} = {nk, q[20], 32'h0, 1'h0};
    @(negedge ref_clk_i);
    {tx_req_i, tx_len_i, tx_frame_opts_i} = {1'h1, len, fo};
    for (int k = 0; k < 400 && !fin; k++) begin
      @(negedge ref_clk_i);
      tx_req_i = 1'h0;
      if (tx_start_o === 1'h1 && n++ == 0) begin
        chk(tx_dest_o, d);
        chk({tx_short_dest_o, tx_bcast_o, tx_mac_ack_o, tx_bcast_pan_o, tx_secure_o},
          {sh, bc, ma, eo[2], eo[4]});
        chk(tx_ack_req_o, !bc && c_rr != 3'h0 && (c_mode == 2'h0 || c_mode == 2'h3));
        chk({tx_src_long_o, tx_encrypt_o}, {c_enc || c_my >= 16'hfffe, c_enc});
      end
      fin = tx_done_o === 1'h1 || tx_fail_o === 1'h1;
    end
    chk(n, ex);
    chk({fin, tx_fail_o}, {1'h1, fl});
  endtask : txr

  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Watchdog well beyond the longest expected run
  initial begin
    #1_500_000;
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    {c_enc, m_slow} = 2'h0;
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'h1;
    for (int i = 0; i < 15; i++) rdc(4'(i), rv[i]);
    for (int i = 0; i < 9; i++) wr(4'(i % 3 + (i > 2 ? 8 : 0)), rnd());
    wr(4'h6, 32'h7);
    for (int i = 0; i < 9; i++) rdc(4'(i), rv[i]);
    coord_addr_i = {rnd(), rnd()};
    wr(4'hb, 32'h4);
    for (int i = 0; i < 6; i++) begin
      evp(6'h20 >> i);
      rdc(4'h0, st[i]);
    end
    rdc(4'h4, coord_addr_i[63:32]);
    rdc(4'h5, coord_addr_i[31:0]);
    wr(4'hb, 32'h0);
    evp(6'h20);
    rdc(4'h0, 32'h13);
    evp(6'h02);
    rdc(4'h0, 32'h00);
    wr(4'h3, 32'h1234);
    rxc(1'h0, 64'h1234, 1'h0, 1'h1, 1'h1, 1'h0);
    wr(4'h3, 32'hfffe);
    rxc(1'h0, 64'hfffe, 1'h0, 1'h1, 1'h0, 1'h0);
    rxc(1'h1, {SU, SL}, 1'h0, 1'h1, 1'h1, 1'h1);
    wr(4'h9, 32'h2);
    rdc(4'h9, 32'h0);
    wr(4'h9, 32'h1);
    rdc(4'h9, 32'h1);
    rdc(4'h8, PE);
    wr(4'h7, 32'h10);
    rdc(4'h8, PE - 8'h04);
    wr(4'h7, 32'h0);
    wr(4'hd, 32'h1);
    rdc(4'h8, 32'h5f);
    wr(4'hd, 32'h0);
    rxc(1'h1, {SU, SL}, 1'h0, 1'h1, 1'h0, 1'h0);
    rxc(1'h1, {SU, SL}, 1'h1, 1'h0, 1'h1, 1'h1);
    {c_enc, c_my, c_mode} = {1'h1, 16'h1234, 2'h1};
    wr(4'h3, 32'h1234);
    wr(4'ha, 32'h1);
    wr(4'hc, 32'h1);
    rxc(1'h0, 64'h1234, 1'h1, 1'h0, 1'h1, 1'h1);
    txr(2'h2, 8'h0, 6'h0);
    wr(4'h9, 32'h0);
    c_enc = 1'h0;
    for (int t = 0; t < 40; t++) begin
      r = rnd();
      {c_mode, c_rr, c_to} = {r[1:0], r[4:2] == 3'h7 ? 3'h6 : r[4:2], 7'h0, r[5]};
      c_my = r[6] ? 16'hfffe : r[23:8];
      wr(4'ha, {30'h0, c_mode});
      wr(4'h6, {29'h0, c_rr});
      wr(4'h7, {24'h0, c_to});
      wr(4'h3, {16'h0, c_my});
      r = rnd();
      txr(r[1:0] == 2'h3 ? 2'h2 : r[1:0], r[9:2] & 8'h15 & {8{r[10]}}, 6'(r[16:11] % 48));
    end
    conclude();
  end
endmodule : radio_tx_addressing_retry_tb_top
